// ===== rtl/mcpwm_top.sv
// Summary of operation
// - down mode counts load to zero, reloads
// - up/down mode counts zero-load-zero triangle
// - direction low in down mode, toggles otherwise
// - one-cycle pulses at zero and load
// - down mode load pulse right after zero
// - two comparators, direction-qualified match pulses
// - match above load never pulses
// - four events down, six up/down
// - matches ignored when zero or load coincide
// - coincident matches: A takes A, B takes B
// - per-event action: keep, toggle, low, high
// - dead-band off passes both signals through
// - dead-band on delays first rising edge
// - second output inverted, delayed, gap low
// - selected raw events raise generator interrupt
// - global sync resets chosen counters together
// - immediate updates apply at next zero
// - synchronised updates wait request, then zero
// - fault forces enabled outputs inactive, interrupts
// - stall: keep running or halt at zero
// - one enable register gates all outputs
// - per-output inversion before the pin
// - sixteen-bit counter, both counting modes
// - three generators, six outputs
module mcpwm_top
	import mcpwm_pkg::*;
#(
	parameter int AW = 12
)(
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            sys_rst,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [AW-1:0]   paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// external conditions
	input  wire logic            faultPin,
	input  wire logic            dbgStall,
	// pins and events
	output logic [2*NGEN-1:0]    pwmPin,
	output logic [NGEN:0]        intrPulse
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		mcpwm_gen_t [NGEN-1:0] gen;
		logic [2*NGEN-1:0]     enable;
		logic [2*NGEN-1:0]     invert;
		logic [2*NGEN-1:0]     faultEn;
		logic [1:0]            faultSy;
		logic [1:0]            stallSy;
		logic                  faultPrev;
		logic [2*NGEN-1:0]     pins;
		logic [NGEN:0]         intr;
		logic [31:0]           rdata;
		logic                  ready;
		logic                  slverr;
	} mcpwm_st_t;

	mcpwm_st_t st_r;
	mcpwm_st_t nx;

	logic [NGEN-1:0]         adv;
	logic [NGEN-1:0]         zeroEv;
	logic [NGEN-1:0]         loadEv;
	logic [NGEN-1:0]         matchA;
	logic [NGEN-1:0]         matchB;
	logic [NGEN-1:0]         upQ;
	logic [NGEN-1:0][EVW-1:0] evt;
	logic [2*NGEN-1:0]       dbOut;
	logic [NGEN-1:0]         syncHit;
	logic                    acc;
	logic                    wrEn;
	logic                    upperZero;
	logic [1:0]              region;
	logic [1:0]              genSel;
	logic                    isGlob;
	logic                    isGen;
	logic [7:0]              off8;
	logic [5:0]              goff;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic applyAct(input logic cur, input mcpwm_act_t code);
		logic res;
		res = cur;
		case (code)
			ACT_TOG:  res = !cur;
			ACT_LOW:  res = 1'b0;
			ACT_HIGH: res = 1'b1;
			default:  res = cur;
		endcase
		return res;
	endfunction

	// own comparator first, so a coincident other match is not seen
	function automatic mcpwm_act_t pickCode(input logic [GENW-1:0] fld,
		input logic [EVW-1:0] ev, input logic primA);
		int f;
		int s;
		logic [1:0] c;
		f = primA ? EV_AUP : EV_BUP;
		s = primA ? EV_BUP : EV_AUP;
		c = ACT_KEEP;
		if (ev[EV_ZERO]) begin
			c = fld[2*EV_ZERO +: 2];
		end else if (ev[EV_LOAD]) begin
			c = fld[2*EV_LOAD +: 2];
		end else if (ev[f] || ev[f+1]) begin
			c = ev[f] ? fld[2*f +: 2] : fld[2*f+2 +: 2];
		end else if (ev[s] || ev[s+1]) begin
			c = ev[s] ? fld[2*s +: 2] : fld[2*s+2 +: 2];
		end
		return mcpwm_act_t'(c);
	endfunction

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign acc       = psel && penable && st_r.ready;
	assign wrEn      = acc && pwrite;
	assign upperZero = paddr[AW-1:8] == '0;
	assign region    = paddr[7:6];
	assign genSel    = region - 2'h1;
	assign off8      = paddr[7:0];
	assign goff      = paddr[5:0];
	assign isGlob    = upperZero && (region == 2'h0);
	assign isGen     = upperZero && (region != 2'h0) && (region <= 2'(NGEN));
	assign syncHit   = (wrEn && isGlob && off8 == OFF_SYNC) ? pwdata[NGEN-1:0] : '0;

	// ------------------------------------------------------------
	// per-generator events and dead-band
	// ------------------------------------------------------------
	// three generators, paired outputs
	for (genvar g = 0; g < NGEN; g++) begin : gGen
		assign adv[g]    = st_r.gen[g].ctl[CTL_RUN] && !st_r.gen[g].halt;
		assign zeroEv[g] = st_r.gen[g].cnt == '0;
		assign loadEv[g] = st_r.gen[g].cnt == st_r.gen[g].loadAct;
		assign matchA[g] = (st_r.gen[g].cnt == st_r.gen[g].cmpAAct)
			&& (st_r.gen[g].cmpAAct <= st_r.gen[g].loadAct);
		assign matchB[g] = (st_r.gen[g].cnt == st_r.gen[g].cmpBAct)
			&& (st_r.gen[g].cmpBAct <= st_r.gen[g].loadAct);
		assign upQ[g]    = st_r.gen[g].ctl[CTL_UPDN] && st_r.gen[g].dirUp;
		// event set, up events only exist in up/down mode
		assign evt[g]    = adv[g] ? {matchB[g] && !upQ[g], matchB[g] && upQ[g],
			matchA[g] && !upQ[g], matchA[g] && upQ[g], loadEv[g], zeroEv[g]} : '0;

		mcpwm_deadband #(
			.DW (DBW)
		) uDb (
			.core_clk (core_clk),
			.sys_rst  (sys_rst),
			.rawA     (st_r.gen[g].pwmA),
			.rawB     (st_r.gen[g].pwmB),
			.dbEn     (st_r.gen[g].dbEn),
			.riseDly  (st_r.gen[g].dbRise),
			.fallDly  (st_r.gen[g].dbFall),
			.outA     (dbOut[2*g]),
			.outB     (dbOut[2*g+1])
		);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		mcpwm_gen_t      gs;
		mcpwm_gen_t      ng;
		logic [CW-1:0]   lv;
		logic [31:0]     rd;
		logic [NGEN-1:0] armV;
		logic            hit;
		logic            lvl;
		nx   = st_r;
		gs   = '0;
		ng   = '0;
		lv   = '0;
		rd   = RST_WORD;
		armV = '0;
		hit  = 1'b0;
		lvl  = 1'b0;
		// two-flop synchronisers; stage 0 feeds stage 1 only
		nx.faultSy   = {st_r.faultSy[0], faultPin};
		nx.stallSy   = {st_r.stallSy[0], dbgStall};
		nx.faultPrev = st_r.faultSy[1];
		nx.intr[NGEN] = st_r.faultSy[1] && !st_r.faultPrev;
		for (int g = 0; g < NGEN; g++) begin
			gs = st_r.gen[g];
			ng = gs;
			lv = gs.loadAct;
			// shadow copy at zero; avoids torn periods
			if (adv[g] && zeroEv[g]) begin
				if (!gs.ctl[CTL_LDSYNC] || gs.updArm) begin
					ng.loadAct = gs.loadSh;
				end
				if (!gs.ctl[CTL_CASYNC] || gs.updArm) begin
					ng.cmpAAct = gs.cmpASh;
				end
				if (!gs.ctl[CTL_CBSYNC] || gs.updArm) begin
					ng.cmpBAct = gs.cmpBSh;
				end
				ng.updArm = 1'b0;
				lv = ng.loadAct;
			end
			if (adv[g]) begin
				if (!gs.ctl[CTL_UPDN]) begin
					ng.cnt = zeroEv[g] ? lv : gs.cnt - 1'b1;
				end else if (gs.dirUp) begin
					if (gs.cnt >= lv) begin
						ng.dirUp = 1'b0;
						ng.cnt   = zeroEv[g] ? gs.cnt : gs.cnt - 1'b1;
					end else begin
						ng.cnt = gs.cnt + 1'b1;
					end
				end else if (zeroEv[g]) begin
					ng.dirUp = 1'b1;
					ng.cnt   = (lv == '0) ? gs.cnt : gs.cnt + 1'b1;
				end else begin
					ng.cnt = gs.cnt - 1'b1;
				end
				// halt at zero unless set to run through
				if (st_r.stallSy[1] && !gs.ctl[CTL_DBGRUN] && zeroEv[g]) begin
					ng.halt  = 1'b1;
					ng.cnt   = gs.cnt;
					ng.dirUp = gs.dirUp;
				end
				ng.pwmA = applyAct(gs.pwmA, pickCode(gs.genA, evt[g], 1'b1));
				ng.pwmB = applyAct(gs.pwmB, pickCode(gs.genB, evt[g], 1'b0));
			end
			// resume on release, or once set to run through
			if (!st_r.stallSy[1] || gs.ctl[CTL_DBGRUN]) begin
				ng.halt = 1'b0;
			end
			// direction held low in down mode
			if (!gs.ctl[CTL_UPDN]) begin
				ng.dirUp = 1'b0;
			end
			if (syncHit[g]) begin
				ng.cnt   = '0;
				ng.dirUp = gs.ctl[CTL_UPDN];
			end
			// arm request; a new request wins over the clear
			if (wrEn && isGlob && off8 == OFF_CTL && pwdata[g]) begin
				ng.updArm = 1'b1;
			end
			armV[g] = gs.updArm;
			if (wrEn && isGen && genSel == 2'(g)) begin
				if (goff == GOFF_CTL) begin
					ng.ctl = pwdata[CTLW-1:0];
				end else if (goff == GOFF_INTEN) begin
					ng.inten = pwdata[EVW-1:0];
				end else if (goff == GOFF_LOAD) begin
					ng.loadSh = pwdata[CW-1:0];
				end else if (goff == GOFF_CMPA) begin
					ng.cmpASh = pwdata[CW-1:0];
				end else if (goff == GOFF_CMPB) begin
					ng.cmpBSh = pwdata[CW-1:0];
				end else if (goff == GOFF_GENA) begin
					ng.genA = pwdata[GENW-1:0];
				end else if (goff == GOFF_GENB) begin
					ng.genB = pwdata[GENW-1:0];
				end else if (goff == GOFF_DBCTL) begin
					ng.dbEn = pwdata[0];
				end else if (goff == GOFF_DBRISE) begin
					ng.dbRise = pwdata[DBW-1:0];
				end else if (goff == GOFF_DBFALL) begin
					ng.dbFall = pwdata[DBW-1:0];
				end
			end
			// raw selected events, dead-band not involved
			nx.intr[g] = |(evt[g] & gs.inten);
			nx.gen[g]  = ng;
		end
		for (int k = 0; k < 2 * NGEN; k++) begin
			lvl = dbOut[k] && st_r.enable[k] && !(st_r.faultSy[1] && st_r.faultEn[k]);
			nx.pins[k] = lvl ^ st_r.invert[k];
		end
		// global register writes
		if (wrEn && isGlob) begin
			if (off8 == OFF_ENABLE) begin
				nx.enable = pwdata[2*NGEN-1:0];
			end else if (off8 == OFF_INVERT) begin
				nx.invert = pwdata[2*NGEN-1:0];
			end else if (off8 == OFF_FAULT) begin
				nx.faultEn = pwdata[2*NGEN-1:0];
			end
		end
		// read mux and decode hit
		if (isGlob) begin
			hit = 1'b1;
			if (off8 == OFF_CTL) begin
				rd = 32'(armV);
			end else if (off8 == OFF_SYNC) begin
				rd = RST_WORD;
			end else if (off8 == OFF_ENABLE) begin
				rd = 32'(st_r.enable);
			end else if (off8 == OFF_INVERT) begin
				rd = 32'(st_r.invert);
			end else if (off8 == OFF_FAULT) begin
				rd = 32'(st_r.faultEn);
			end else if (off8 == OFF_STATUS) begin
				rd = 32'({st_r.stallSy[1], st_r.faultSy[1]});
			end else begin
				hit = 1'b0;
			end
		end else if (isGen) begin
			gs  = st_r.gen[genSel];
			hit = 1'b1;
			if (goff == GOFF_CTL) begin
				rd = 32'(gs.ctl);
			end else if (goff == GOFF_INTEN) begin
				rd = 32'(gs.inten);
			end else if (goff == GOFF_LOAD) begin
				rd = 32'(gs.loadSh);
			end else if (goff == GOFF_COUNT) begin
				rd = 32'(gs.cnt);
			end else if (goff == GOFF_CMPA) begin
				rd = 32'(gs.cmpASh);
			end else if (goff == GOFF_CMPB) begin
				rd = 32'(gs.cmpBSh);
			end else if (goff == GOFF_GENA) begin
				rd = 32'(gs.genA);
			end else if (goff == GOFF_GENB) begin
				rd = 32'(gs.genB);
			end else if (goff == GOFF_DBCTL) begin
				rd = 32'(gs.dbEn);
			end else if (goff == GOFF_DBRISE) begin
				rd = 32'(gs.dbRise);
			end else if (goff == GOFF_DBFALL) begin
				rd = 32'(gs.dbFall);
			end else begin
				hit = 1'b0;
			end
		end
		// one wait state: answer in the second access cycle
		nx.ready  = psel && penable && !st_r.ready;
		nx.rdata  = (nx.ready && !pwrite) ? rd : RST_WORD;
		nx.slverr = nx.ready && !hit;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= nx;
		end
	end

	// outputs straight from flops
	assign prdata    = st_r.rdata;
	assign pready    = st_r.ready;
	assign pslverr   = st_r.slverr;
	assign pwmPin    = st_r.pins;
	assign intrPulse = st_r.intr;

	// ------------------------------------------------------------
	// checks on generator 0
	// ------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	dn_reload_a: assert property (adv[0] && !st_r.gen[0].ctl[CTL_UPDN] && zeroEv[0]
		&& !st_r.stallSy[1] && !syncHit[0] |=> st_r.gen[0].cnt == st_r.gen[0].loadAct)
		else $error("down count did not reload");
	dn_step_a: assert property (adv[0] && !st_r.gen[0].ctl[CTL_UPDN] && !zeroEv[0]
		&& !syncHit[0] |=> st_r.gen[0].cnt == $past(st_r.gen[0].cnt) - 16'h0001)
		else $error("down count did not decrement");
	ud_climb_a: assert property (adv[0] && upQ[0] && !zeroEv[0] && !syncHit[0]
		&& st_r.gen[0].cnt < st_r.gen[0].loadAct
		|=> st_r.gen[0].cnt == $past(st_r.gen[0].cnt) + 16'h0001)
		else $error("up count did not increment");
	dir_low_a: assert property (!st_r.gen[0].ctl[CTL_UPDN] |=> !st_r.gen[0].dirUp)
		else $error("direction high in down mode");
	ld_follow_a: assert property (adv[0] && !st_r.gen[0].ctl[CTL_UPDN] && zeroEv[0]
		&& !st_r.stallSy[1] && !syncHit[0] |=> loadEv[0])
		else $error("load pulse missing after zero");
	cmp_over_a: assert property (st_r.gen[0].cmpAAct > st_r.gen[0].loadAct |-> !matchA[0])
		else $error("match above load pulsed");
	gen_keep_a: assert property (st_r.gen[0].genA == '0 |=> $stable(st_r.gen[0].pwmA))
		else $error("signal moved with no actions");
	sync_zero_a: assert property (syncHit[0] |=> st_r.gen[0].cnt == '0)
		else $error("sync did not clear counter");
	irq_sel_a: assert property (|(evt[0] & st_r.gen[0].inten) |=> intrPulse[0])
		else $error("selected event gave no interrupt");
	stall_quiet_a: assert property (st_r.gen[0].halt |=> !intrPulse[0])
		else $error("halted generator interrupted");
	flt_force_a: assert property (st_r.faultSy[1] && st_r.faultEn[0] && !st_r.invert[0]
		|=> !pwmPin[0])
		else $error("fault did not force output");
	out_gate_a: assert property (!st_r.enable[0] |=> pwmPin[0] == $past(st_r.invert[0]))
		else $error("disabled output not at idle level");

endmodule

// ===== rtl/mcpwm_pkg.sv
package mcpwm_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NGEN = 3;
	localparam int CW   = 16;
	localparam int DBW  = 12;
	localparam int CTLW = 6;
	localparam int EVW  = 6;
	localparam int GENW = 2 * EVW;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTL    = 8'h00;
	localparam logic [7:0] OFF_SYNC   = 8'h04;
	localparam logic [7:0] OFF_ENABLE = 8'h08;
	localparam logic [7:0] OFF_INVERT = 8'h0c;
	localparam logic [7:0] OFF_FAULT  = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [5:0] GOFF_CTL    = 6'h00;
	localparam logic [5:0] GOFF_INTEN  = 6'h04;
	localparam logic [5:0] GOFF_LOAD   = 6'h10;
	localparam logic [5:0] GOFF_COUNT  = 6'h14;
	localparam logic [5:0] GOFF_CMPA   = 6'h18;
	localparam logic [5:0] GOFF_CMPB   = 6'h1c;
	localparam logic [5:0] GOFF_GENA   = 6'h20;
	localparam logic [5:0] GOFF_GENB   = 6'h24;
	localparam logic [5:0] GOFF_DBCTL  = 6'h28;
	localparam logic [5:0] GOFF_DBRISE = 6'h2c;
	localparam logic [5:0] GOFF_DBFALL = 6'h30;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_RUN    = 0;
	localparam int CTL_UPDN   = 1;
	localparam int CTL_DBGRUN = 2;
	localparam int CTL_LDSYNC = 3;
	localparam int CTL_CASYNC = 4;
	localparam int CTL_CBSYNC = 5;
	localparam int EV_ZERO = 0;
	localparam int EV_LOAD = 1;
	localparam int EV_AUP  = 2;
	localparam int EV_ADN  = 3;
	localparam int EV_BUP  = 4;
	localparam int EV_BDN  = 5;

	typedef enum logic [1:0] {
		ACT_KEEP = 2'b00,
		ACT_TOG  = 2'b01,
		ACT_LOW  = 2'b10,
		ACT_HIGH = 2'b11
	} mcpwm_act_t;

	typedef struct packed {
		logic [CTLW-1:0] ctl;
		logic [EVW-1:0]  inten;
		logic [GENW-1:0] genA;
		logic [GENW-1:0] genB;
		logic            dbEn;
		logic [DBW-1:0]  dbRise;
		logic [DBW-1:0]  dbFall;
		logic [CW-1:0]   loadSh;
		logic [CW-1:0]   cmpASh;
		logic [CW-1:0]   cmpBSh;
		logic [CW-1:0]   loadAct;
		logic [CW-1:0]   cmpAAct;
		logic [CW-1:0]   cmpBAct;
		logic [CW-1:0]   cnt;
		logic            dirUp;
		logic            halt;
		logic            updArm;
		logic            pwmA;
		logic            pwmB;
	} mcpwm_gen_t;

endpackage

// ===== rtl/mcpwm_deadband.sv
module mcpwm_deadband
	import mcpwm_pkg::*;
#(
	parameter int DW = DBW
)(
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	// raw pair and setup
	input  wire logic          rawA,
	input  wire logic          rawB,
	input  wire logic          dbEn,
	input  wire logic [DW-1:0] riseDly,
	input  wire logic [DW-1:0] fallDly,
	// conditioned pair
	output logic               outA,
	output logic               outB
);

	typedef struct packed {
		logic          prevIn;
		logic [DW-1:0] runCnt;
		logic          outA;
		logic          outB;
	} mcpwm_db_t;

	mcpwm_db_t st_r;
	mcpwm_db_t nx;

	// run length of the first raw signal, saturating so long levels hold
	always_comb begin
		nx = st_r;
		nx.prevIn = rawA;
		if (rawA != st_r.prevIn) begin
			nx.runCnt = '0;
		end else if (st_r.runCnt != '1) begin
			nx.runCnt = st_r.runCnt + 1'b1;
		end
		if (dbEn) begin
			nx.outA = rawA && (nx.runCnt >= riseDly);
			nx.outB = !rawA && (nx.runCnt >= fallDly);
		end else begin
			nx.outA = rawA;
			nx.outB = rawB;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= nx;
		end
	end

	assign outA = st_r.outA;
	assign outB = st_r.outB;

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	db_gap_a: assert property (dbEn |=> !(outA && outB))
		else $error("dead-band pair both high");
	db_pass_a: assert property (!dbEn |=> outB == $past(rawB))
		else $error("bypass altered second signal");
	db_rise_a: assert property (dbEn && !rawA |=> !outA)
		else $error("first output high while input low");

endmodule

// ===== test/mcpwm_gate_model.sv
module mcpwm_gate_model (
	// clock and clear
	input  wire logic       core_clk,
	input  wire logic       clrCnt,
	// gate pins from the unit
	input  wire logic [5:0] pwmPin,
	// cycles with both legs of bridge 0 on
	output int              shootCnt
);
	timeunit 1ns;
	timeprecision 1ps;

	// legs can overlap while the dead-band is off
	// a real bridge shorts its rail here, so every such cycle counts
	always @(posedge core_clk) begin
		if (clrCnt) begin
			shootCnt <= 0;
		end else if (pwmPin[0] === 1'b1 && pwmPin[1] === 1'b1) begin
			shootCnt <= shootCnt + 1;
		end
	end
endmodule

// ===== test/tb.sv
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin errCount++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mcpwm_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	typedef struct {
		logic [15:0] ctl, ld, ca, cb, ga, gb, en, inv, db, e0, e1, ei, sh;
	} mcpwm_row_t;

	logic        core_clk, sys_rst, psel, penable, pwrite, faultPin, dbgStall, clrCnt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, rerr;
	logic [5:0]  pwmPin;
	logic [3:0]  intrPulse;
	int          errCount, totalChecks, shootCnt, hi0, hi1, ir0, ir3, dif;

	// high-cycle counts over 180 cycles, one down period 10, one up/down period 18
	mcpwm_row_t rows [8] = '{
	// last column: cycles with both legs of bridge 0 high
		'{1, 9, 4, 12, 'h83, 'h803, 'h3f, 0, 0, 108, 180, 36, 108},
		'{1, 9, 9, 4, 'h83, 'h803, 'h3f, 0, 0, 180, 108, 36, 108},
		'{1, 9, 4, 4, 'h803, 'h83, 'h3f, 0, 0, 180, 180, 36, 180},
		'{3, 9, 4, 6, 'hb0, 'hb00, 'h3f, 0, 0, 100, 60, 20, 60},
		'{1, 9, 4, 4, 'h1, 'h2, 'h3f, 0, 0, 90, 0, 36, 0},
		'{1, 9, 4, 12, 'h83, 'h803, 'h3f, 'h3, 0, 72, 0, 36, 0},
		'{1, 9, 4, 12, 'h83, 'h803, 'h2, 0, 0, 0, 180, 36, 0},
		'{1, 9, 4, 12, 'h83, 'h803, 'h3f, 0, 1, 54, 36, 36, 0}
	};

	mcpwm_top #(.AW(12)) DUT (
		.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .faultPin(faultPin),
		.dbgStall(dbgStall), .pwmPin(pwmPin), .intrPulse(intrPulse)
	);

	mcpwm_gate_model DRV (
		.core_clk(core_clk), .clrCnt(clrCnt), .pwmPin(pwmPin), .shootCnt(shootCnt)
	);

	// 250 MHz module clock
	always #2 core_clk = ~core_clk;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task give_verdict;
		$display("checks=%0d errors=%0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			errCount++;
			give_verdict();
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task rst;
		sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
	endtask

	// load one generator; run bits last so it starts on settled values
	task automatic gen(input logic [11:0] b, input mcpwm_row_t r);
		apb(1'b1, b + 12'(GOFF_LOAD), 32'(r.ld));
		apb(1'b1, b + 12'(GOFF_CMPA), 32'(r.ca));
		apb(1'b1, b + 12'(GOFF_CMPB), 32'(r.cb));
		apb(1'b1, b + 12'(GOFF_GENA), 32'(r.ga));
		apb(1'b1, b + 12'(GOFF_GENB), 32'(r.gb));
		apb(1'b1, b + 12'(GOFF_DBCTL), 32'(r.db));
		apb(1'b1, b + 12'(GOFF_DBRISE), 32'h3);
		apb(1'b1, b + 12'(GOFF_DBFALL), 32'h2);
		apb(1'b1, b + 12'(GOFF_INTEN), 32'h3);
		apb(1'b1, b + 12'(GOFF_CTL), 32'(r.ctl));
	endtask

	// count high cycles of pins and events over a window
	task automatic meas(input int w);
		hi0 = 0;
		hi1 = 0;
		ir0 = 0;
		ir3 = 0;
		dif = 0;
		clrCnt <= 1'b1;
		@(posedge core_clk);
		clrCnt <= 1'b0;
		repeat (w) begin
			@(posedge core_clk);
			hi0 += (pwmPin[0] === 1'b1);
			hi1 += (pwmPin[1] === 1'b1);
			ir0 += (intrPulse[0] === 1'b1);
			ir3 += (intrPulse[3] === 1'b1);
			dif += (intrPulse[0] !== intrPulse[1]) || (intrPulse[0] !== intrPulse[2]);
		end
		// one more edge so the partner's count for the last edge has landed
		@(posedge core_clk);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		{sys_rst, psel, penable, pwrite, faultPin, dbgStall, clrCnt} = '0;
		paddr = '0;
		pwdata = '0;
		errCount = 0;
		totalChecks = 0;
		rst();
		apb(1'b0, 12'(OFF_ENABLE), 0);
		`CHK(rdat, RST_WORD)
		`CHK(pwmPin, 6'h00)
		apb(1'b1, 12'h050, 32'h0001_2345);
		apb(1'b0, 12'h050, 0);
		`CHK(rdat, 32'h0000_2345)
		apb(1'b0, 12'h014, 0);
		`CHK(rerr, 1'b1)
		foreach (rows[i]) begin
			rst();
			apb(1'b1, 12'(OFF_ENABLE), 32'(rows[i].en));
			apb(1'b1, 12'(OFF_INVERT), 32'(rows[i].inv));
			gen(12'h040, rows[i]);
			repeat (40) @(posedge core_clk);
			meas(180);
			`CHK(hi0, int'(rows[i].e0))
			`CHK(hi1, int'(rows[i].e1))
			`CHK(ir0, int'(rows[i].ei))
			`CHK(shootCnt, int'(rows[i].sh))
		end
		// fault: pin A forced inactive, pin B left alone, one event pulse
		rst();
		apb(1'b1, 12'(OFF_ENABLE), 32'h3f);
		apb(1'b1, 12'(OFF_FAULT), 32'h1);
		gen(12'h040, rows[0]);
		repeat (40) @(posedge core_clk);
		faultPin <= 1'b1;
		meas(30);
		`CHK(ir3, 1)
		meas(20);
		`CHK(hi0, 0)
		`CHK(hi1, 20)
		apb(1'b1, 12'(OFF_INVERT), 32'h1);
		repeat (5) @(posedge core_clk);
		meas(20);
		`CHK(hi0, 20)
		faultPin <= 1'b0;
		// three generators started apart, then aligned by one write
		rst();
		gen(12'h040, rows[0]);
		repeat (7) @(posedge core_clk);
		gen(12'h080, rows[0]);
		gen(12'h0c0, rows[0]);
		apb(1'b1, 12'(OFF_SYNC), 32'h7);
		repeat (20) @(posedge core_clk);
		meas(180);
		`CHK(dif, 0)
		// immediate, then held, then requested load updates
		apb(1'b1, 12'h050, 32'h4);
		repeat (20) @(posedge core_clk);
		meas(180);
		`CHK(ir0, 72)
		apb(1'b1, 12'h040, 32'h9);
		apb(1'b1, 12'h050, 32'h9);
		repeat (20) @(posedge core_clk);
		meas(180);
		`CHK(ir0, 72)
		apb(1'b1, 12'(OFF_CTL), 32'h1);
		repeat (20) @(posedge core_clk);
		meas(180);
		`CHK(ir0, 36)
		// stall: halt at zero without events, then keep running
		apb(1'b1, 12'h040, 32'h1);
		dbgStall <= 1'b1;
		repeat (40) @(posedge core_clk);
		meas(20);
		`CHK(ir0, 0)
		`CHK(ir3, 0)
		apb(1'b0, 12'h054, 0);
		`CHK(rdat, 32'h0)
		apb(1'b1, 12'h040, 32'h5);
		repeat (20) @(posedge core_clk);
		meas(180);
		`CHK(ir0, 36)
		dbgStall <= 1'b0;
		give_verdict();
	end
endmodule
